// *** common/sbrg_pkg.sv ***
// Constants shared by the serial baud rate generator design files
package sbrg_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] SBRG_OFS_TXCTL = 8'h00;
    localparam logic [7:0] SBRG_OFS_RXCTL = 8'h04;
    localparam logic [7:0] SBRG_OFS_DIV = 8'h08;
    localparam logic [7:0] SBRG_OFS_STAT = 8'h0c;

    // ----------------------------------------------------------------
    // Transmit control fields
    // ----------------------------------------------------------------
    localparam int SBRG_TX_CLKSRC = 7;
    localparam int SBRG_TX_SYNC = 4;
    localparam int SBRG_TX_HSPEED = 2;
    localparam int SBRG_TX_EMPTY = 1;
    localparam logic [7:0] SBRG_TX_RESET = 8'h02;
    localparam logic [7:0] SBRG_TX_WMASK = 8'hf5;

    // ----------------------------------------------------------------
    // Receive control fields
    // ----------------------------------------------------------------
    localparam int SBRG_RX_ENABLE = 7;
    localparam logic [7:0] SBRG_RX_RESET = 8'h00;
    localparam logic [7:0] SBRG_RX_WMASK = 8'hf8;

    // ----------------------------------------------------------------
    // Divisor, timing and bus transfer type
    // ----------------------------------------------------------------
    localparam logic [7:0] SBRG_DIV_RESET = 8'h00;
    localparam logic [1:0] SBRG_QUARTER_LAST = 2'h3;
    localparam logic [3:0] SBRG_PRE_LOW = 4'hf;
    localparam logic [3:0] SBRG_PRE_HIGH = 4'h3;
    localparam logic [3:0] SBRG_PRE_SYNC = 4'h0;
    localparam logic [1:0] SBRG_CK_HIGH_LAST = 2'h1;
    localparam logic [1:0] SBRG_HTRANS_NONSEQ = 2'h2;

endpackage : sbrg_pkg

// *** design/sbrg_timer.sv ***
// Free-running reloadable down counter of the baud generator
module sbrg_timer #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic step,
    input wire logic clear,
    input wire logic [WIDTH-1:0] reload,
    // Result
    output logic tick,
    output logic [WIDTH-1:0] count
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic tick_q;
    wire at_zero = (count_q == '0);

    // Period is reload plus one steps
    assign count_d = clear ? '0 :
                     !step ? count_q :
                     at_zero ? reload : count_q - 1'b1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
            tick_q <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q <= step && at_zero && !clear;
        end
    end

    assign tick = tick_q;
    assign count = count_q;
endmodule : sbrg_timer

// *** design/sbrg_top.sv ***
// Baud rate generator with AHB-Lite register access
//
// Our own choices: the register offsets and the AHB-Lite slave port.
module sbrg_top #(
    parameter int DIV_WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Status from transmitter and receiver
    input wire logic tx_shift_empty,
    input wire logic [2:0] rx_status,
    // Serial pins
    input wire logic receive_data_pin,
    input wire logic ck_i,
    output logic ck_o,
    output logic ck_oe,
    // Clocks and levels for the shift logic
    output logic baud_tick,
    output logic sample_tick,
    output logic rx_level,
    output logic [7:0] transmit_control_status,
    output logic [7:0] receive_control_status
);
    import sbrg_pkg::*;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic hresp_q;

    // Size is not decoded: every access is taken as one word
    wire take = hsel && hready && (htrans == SBRG_HTRANS_NONSEQ);
    wire take_rd = take && !hwrite;
    wire take_wr = take && hwrite;

    // Writes land at the end of their data phase
    wire wr_tx = wr_pend_q && (wr_addr_q == SBRG_OFS_TXCTL);
    wire wr_rx = wr_pend_q && (wr_addr_q == SBRG_OFS_RXCTL);
    wire wr_div = wr_pend_q && (wr_addr_q == SBRG_OFS_DIV);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] txctl_q;
    logic [7:0] txctl_d;
    logic [7:0] rxctl_q;
    logic [7:0] rxctl_d;
    logic [DIV_WIDTH-1:0] div_q;
    logic [DIV_WIDTH-1:0] div_d;

    // Only writable bits take bus data; transmit control bit 3 stays zero
    assign txctl_d = wr_tx ?
        ((hwdata[7:0] & SBRG_TX_WMASK) | (txctl_q & ~SBRG_TX_WMASK)) :
        txctl_q;
    assign rxctl_d = wr_rx ?
        ((hwdata[7:0] & SBRG_RX_WMASK) | (rxctl_q & ~SBRG_RX_WMASK)) :
        rxctl_q;
    // Any value 0 to 255 is accepted as it stands
    assign div_d = wr_div ? hwdata[DIV_WIDTH-1:0] : div_q;

    // ----------------------------------------------------------------
    // Mode selection
    // ----------------------------------------------------------------
    wire port_on = rxctl_q[SBRG_RX_ENABLE];
    wire sync_mode = txctl_q[SBRG_TX_SYNC];
    wire high_speed = txctl_q[SBRG_TX_HSPEED];
    wire clk_master = txctl_q[SBRG_TX_CLKSRC];
    // Clock source only matters when synchronous
    wire sync_slave = sync_mode && !clk_master;
    wire sync_master = sync_mode && clk_master;

    // High speed is looked at only outside synchronous mode
    wire [3:0] pre_last = sync_mode ? SBRG_PRE_SYNC :
                          high_speed ? SBRG_PRE_HIGH :
                          SBRG_PRE_LOW;

    // ----------------------------------------------------------------
    // Quarter-rate step and baud timer
    // ----------------------------------------------------------------
    logic [1:0] quarter_q;
    logic [1:0] quarter_d;
    logic timer_tick;
    logic [DIV_WIDTH-1:0] timer_count;

    // Timer steps once per four clocks, giving the factor four
    // common to every ratio
    assign quarter_d = wr_div ? 2'h0 : quarter_q + 2'h1;
    wire quarter_step = (quarter_q == SBRG_QUARTER_LAST) && !wr_div;

    sbrg_timer #(
        .WIDTH(DIV_WIDTH)
    ) u_timer (
        .clk(clk),
        .rstn(rstn),
        .step(quarter_step),
        .clear(wr_div),
        .reload(div_q),
        .tick(timer_tick),
        .count(timer_count)
    );

    // ----------------------------------------------------------------
    // Prescaler after the timer
    // ----------------------------------------------------------------
    logic [3:0] pre_q;
    logic [3:0] pre_d;
    wire pre_wrap = timer_tick && (pre_q >= pre_last);

    // A timer tick already in flight at a divisor write is dropped
    assign pre_d = wr_div ? 4'h0 :
                   !timer_tick ? pre_q :
                   pre_wrap ? 4'h0 : pre_q + 4'h1;

    // ----------------------------------------------------------------
    // Slave clock from outside
    // ----------------------------------------------------------------
    logic ck_prev_q;
    wire ck_rise = ck_i && !ck_prev_q;

    // Master uses the divider, slave follows the external clock
    wire int_tick = pre_wrap && !wr_div && !sync_slave;
    wire ext_tick = sync_slave && ck_rise;
    wire tick_d = port_on && (int_tick || ext_tick);

    // ----------------------------------------------------------------
    // Synchronous master clock output
    // ----------------------------------------------------------------
    logic [1:0] ck_cnt_q;
    logic [1:0] ck_cnt_d;
    logic ck_o_q;
    logic ck_oe_q;

    // Pin goes high on each bit tick and holds for two clocks;
    // with divisor 0 this is an even duty cycle
    assign ck_cnt_d = (tick_d && sync_master) ? 2'h0 :
                      (ck_cnt_q != SBRG_CK_HIGH_LAST) ? ck_cnt_q + 2'h1 :
                      ck_cnt_q;
    wire ck_o_d = sync_master && port_on &&
                  ((tick_d) || (ck_o_q && ck_cnt_q != SBRG_CK_HIGH_LAST));
    wire ck_oe_d = sync_master && port_on;

    // ----------------------------------------------------------------
    // Receive pin majority detect
    // ----------------------------------------------------------------
    logic vote_level;
    logic sample_q;
    // Sampled on each timer tick, oversampled outside synchronous mode; slave samples on clock edges
    wire sample_d = port_on &&
                    (sync_slave ? ck_rise : (timer_tick && !wr_div));

    sbrg_vote u_vote (
        .clk(clk),
        .rstn(rstn),
        .sample(sample_d),
        .pin(receive_data_pin),
        .level(vote_level)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Next values are read so a read right after a write sees it
    wire [7:0] tx_view = {txctl_d[7:2], tx_shift_empty, txctl_d[0]};
    wire [7:0] rx_view = {rxctl_d[7:3], rx_status};
    wire [31:0] stat_view = {16'h0000, timer_count, 4'h0, pre_q[3:2],
                             sync_master, vote_level};
    wire [31:0] rd_mux =
        (haddr == SBRG_OFS_TXCTL) ? {24'h000000, tx_view} :
        (haddr == SBRG_OFS_RXCTL) ? {24'h000000, rx_view} :
        (haddr == SBRG_OFS_DIV) ? {24'h000000, div_d} :
        (haddr == SBRG_OFS_STAT) ? stat_view : 32'h00000000;

    // ----------------------------------------------------------------
    // Output copies of the control registers, bit tick and receive level
    // ----------------------------------------------------------------
    logic [7:0] tx_out_q;
    logic [7:0] rx_out_q;
    logic baud_tick_q;
    logic rx_level_q;

    // ----------------------------------------------------------------
    // Flip-flops
    // ----------------------------------------------------------------
    // Bus answers in the cycle after the address phase and never waits
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= take_wr;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_addr_q <= 8'h00;
        end else begin
            wr_addr_q <= take_wr ? haddr : wr_addr_q;
        end
    end

    // Read data is zero outside its data phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hrdata_q <= 32'h00000000;
        end else begin
            hrdata_q <= take_rd ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
        end
    end

    // Control registers hold until software writes them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txctl_q <= SBRG_TX_RESET;
        end else begin
            txctl_q <= txctl_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxctl_q <= SBRG_RX_RESET;
        end else begin
            rxctl_q <= rxctl_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= SBRG_DIV_RESET;
        end else begin
            div_q <= div_d;
        end
    end

    // Divider state, all of it cleared by a divisor write
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quarter_q <= 2'h0;
        end else begin
            quarter_q <= quarter_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_q <= 4'h0;
        end else begin
            pre_q <= pre_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_i;
        end
    end

    // Count parks at its last value, so the pin rests low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_cnt_q <= SBRG_CK_HIGH_LAST;
        end else begin
            ck_cnt_q <= ck_cnt_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_o_q <= 1'b0;
        end else begin
            ck_o_q <= ck_o_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_oe_q <= 1'b0;
        end else begin
            ck_oe_q <= ck_oe_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            baud_tick_q <= 1'b0;
            sample_q <= 1'b0;
            rx_level_q <= 1'b1;
            tx_out_q <= SBRG_TX_RESET;
            rx_out_q <= SBRG_RX_RESET;
        end else begin
            baud_tick_q <= tick_d;
            sample_q <= sample_d;
            rx_level_q <= vote_level;
            tx_out_q <= {txctl_q[7:2], tx_shift_empty, txctl_q[0]};
            rx_out_q <= rxctl_q;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign hreadyout = hreadyout_q;
    assign hresp = hresp_q;
    assign hrdata = hrdata_q;
    assign ck_o = ck_o_q;
    assign ck_oe = ck_oe_q;
    assign baud_tick = baud_tick_q;
    assign sample_tick = sample_q;
    assign rx_level = rx_level_q;
    assign transmit_control_status = tx_out_q;
    assign receive_control_status = rx_out_q;

endmodule : sbrg_top

// *** design/sbrg_vote.sv ***
// Three-sample majority detector for the receive data pin
module sbrg_vote (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Sampling
    input wire logic sample,
    input wire logic pin,
    // Decided level
    output logic level
);
    logic [2:0] hist_q;
    logic level_q;
    wire [2:0] hist_d = sample ? {hist_q[1:0], pin} : hist_q;
    wire vote = (hist_d[0] & hist_d[1]) | (hist_d[1] & hist_d[2]) |
                (hist_d[0] & hist_d[2]);

    // Idle line is high, so history starts high
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hist_q <= 3'h7;
            level_q <= 1'b1;
        end else begin
            hist_q <= hist_d;
            level_q <= vote;
        end
    end

    assign level = level_q;
endmodule : sbrg_vote

// *** testbench/sbrg_props.sv ***
// Concurrent checks on the ports of the baud rate generator
module sbrg_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // Pins and ticks
    input wire logic ck_i,
    input wire logic ck_o,
    input wire logic ck_oe,
    input wire logic baud_tick,
    input wire logic sample_tick,
    input wire logic [7:0] transmit_control_status,
    input wire logic [7:0] receive_control_status
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbrg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic [7:0] tcs = transmit_control_status;
    wire logic master = tcs[SBRG_TX_SYNC] & tcs[SBRG_TX_CLKSRC];
    wire logic slave = tcs[SBRG_TX_SYNC] & !tcs[SBRG_TX_CLKSRC];
    wire logic port_on = receive_control_status[SBRG_RX_ENABLE];
    wire logic rd_req = hsel & (htrans == SBRG_HTRANS_NONSEQ) & !hwrite;
    // --------------------------------------------------------
    // Sequences
    // --------------------------------------------------------
    sequence s_high2;
        ck_o [*2] ##1 !ck_o;
    endsequence
    sequence s_quiet3;
        !sample_tick [*3];
    endsequence
    // --------------------------------------------------------
    // Properties
    // --------------------------------------------------------
    chk_tick_pulse: assert property (
        baud_tick |=> !baud_tick) else $error("baud tick too long");
    chk_sample_gap: assert property (
        sample_tick && !slave |=> s_quiet3)
        else $error("timer steps too close");
    chk_idle_quiet: assert property (
        !port_on [*3] |-> !baud_tick && !sample_tick)
        else $error("tick while port disabled");
    chk_master_oe: assert property (
        (master && port_on) [*3] |-> ck_oe)
        else $error("master clock not driven");
    chk_other_oe: assert property (
        !master [*3] |-> !ck_oe)
        else $error("clock driven outside master mode");
    chk_ck_high: assert property (
        master && $rose(ck_o) |-> s_high2) else $error("bit clock high time");
    chk_slave_tick: assert property (
        slave && port_on && $rose(ck_i) |-> ##[1:2] baud_tick)
        else $error("no tick on external clock");
    chk_rd_idle: assert property (
        !rd_req |=> hrdata == 32'h0)
        else $error("read data outside data phase");
    chk_bus_okay: assert property (
        hreadyout |=> hreadyout && !hresp) else $error("bus wait or error");
endmodule : sbrg_props

bind sbrg_top sbrg_props u_props (.clk(clk), .rstn(rstn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ck_i(ck_i), .ck_o(ck_o), .ck_oe(ck_oe),
    .baud_tick(baud_tick), .sample_tick(sample_tick),
    .transmit_control_status(transmit_control_status),
    .receive_control_status(receive_control_status));

// *** testbench/tb_sbrg_top.sv ***
// Self-checking testbench of the baud rate generator
module tb_sbrg_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sbrg_pkg::*;
    logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr, x, ex, tcs, rcs;
    logic [1:0] htrans;
    logic [2:0] hsize, rx_status;
    logic [31:0] hwdata, hrdata;
    logic tx_shift_empty, receive_data_pin, ck_i, ck_o, ck_oe;
    logic baud_tick, sample_tick, rx_level;
    logic rd_dp = 1'b0;
    logic [31:0] exp_rd[$];
    logic [31:0] exp_per[$];
    logic [7:0] modes[5] = '{8'h00, 8'h04, 8'h90, 8'h94, 8'h80};
    int mult[5] = '{64, 16, 4, 4, 64};
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int per_cnt = 0;
    int i, n;
    assign hready = hreadyout;
    sbrg_top u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .tx_shift_empty(tx_shift_empty),
        .rx_status(rx_status), .receive_data_pin(receive_data_pin),
        .ck_i(ck_i), .ck_o(ck_o), .ck_oe(ck_oe), .baud_tick(baud_tick),
        .sample_tick(sample_tick), .rx_level(rx_level),
        .transmit_control_status(tcs), .receive_control_status(rcs));
    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    task automatic cmp(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : cmp
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= SBRG_HTRANS_NONSEQ;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Skip two ticks so a restarted first period is never measured
    task automatic per(input int p);
        repeat (2) @(posedge baud_tick);
        @(negedge clk);
        exp_per.push_back(p);
        while (exp_per.size() > 0) @(posedge clk);
    endtask : per
    task automatic ckp;
        ck_i <= 1'b1;
        repeat (4) @(posedge clk);
        ck_i <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : ckp
    // --------------------------------------------------------
    // Clock, watcher and timeout
    // --------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (rd_dp && exp_rd.size() > 0) begin
            cmp("hrdata", exp_rd.pop_front(), hrdata);
        end
        rd_dp = hsel && hready && htrans == SBRG_HTRANS_NONSEQ && !hwrite;
        if (baud_tick === 1'b1) begin
            if (exp_per.size() > 0) begin
                cmp("baud", exp_per.pop_front(), per_cnt);
            end
            per_cnt = 1;
        end else begin
            per_cnt++;
        end
        if (cyc == 60000) begin
            bad_count++;
            test_done();
        end
    end
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        rstn = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tx_shift_empty = 1'b1;
        receive_data_pin = 1'b1;
        ck_i = 1'b0;
        n = $urandom(25976);
        rx_status = 3'($urandom);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rd(SBRG_OFS_TXCTL, 32'h02);
        rd(SBRG_OFS_RXCTL, {29'h0, rx_status});
        rd(SBRG_OFS_DIV, 32'h0);
        rd(8'h10, 32'h0);
        cmp("tx_copy", 32'h02, {24'h0, tcs});
        cmp("rx_copy", 32'h0, {24'h0, rcs});
        // A divisor write must clear a timer that is part way down
        bus(1'b1, SBRG_OFS_DIV, 32'hff);
        repeat (9) @(posedge clk);
        bus(1'b1, SBRG_OFS_DIV, 32'h10);
        rd(SBRG_OFS_STAT, 32'h1);
        for (i = 0; i < 4; i++) begin
            x = 8'($urandom);
            tx_shift_empty <= 1'($urandom);
            bus(1'b1, SBRG_OFS_DIV, {24'h0, x});
            bus(1'b1, 8'h14, 32'hff);
            rd(SBRG_OFS_DIV, {24'h0, x});
            bus(1'b1, SBRG_OFS_TXCTL, {24'h0, x});
            ex = x & SBRG_TX_WMASK | {6'h0, tx_shift_empty, 1'b0};
            rd(SBRG_OFS_TXCTL, {24'h0, ex});
            cmp("tx_copy", {24'h0, ex}, {24'h0, tcs});
            bus(1'b1, SBRG_OFS_RXCTL, {24'h0, x});
            ex = x & SBRG_RX_WMASK;
            rd(SBRG_OFS_RXCTL, {24'h0, ex | {5'h0, rx_status}});
            cmp("rx_copy", {24'h0, ex}, {24'h0, rcs});
        end
        bus(1'b1, SBRG_OFS_RXCTL, 32'h80);
        for (i = 0; i < 5; i++) begin
            x = 8'($urandom_range(7));
            bus(1'b1, SBRG_OFS_TXCTL, {24'h0, modes[i]});
            bus(1'b1, SBRG_OFS_DIV, {24'h0, x});
            per(mult[i] * (x + 1));
        end
        bus(1'b1, SBRG_OFS_TXCTL, 32'h04);
        bus(1'b1, SBRG_OFS_DIV, 32'hff);
        per(16 * 256);
        // A slow count in flight must not delay the new rate
        bus(1'b1, SBRG_OFS_TXCTL, 32'h00);
        repeat (300) @(posedge clk);
        bus(1'b1, SBRG_OFS_TXCTL, 32'h04);
        bus(1'b1, SBRG_OFS_DIV, 32'h00);
        n = 0;
        while (baud_tick !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
        end
        cmp("restart", 32'h1, {31'h0, n <= 20});
        bus(1'b1, SBRG_OFS_TXCTL, 32'h10);
        receive_data_pin <= 1'b0;
        repeat (3) ckp();
        cmp("rx_level", 32'h0, {31'h0, rx_level});
        receive_data_pin <= 1'b1;
        ckp();
        cmp("rx_level", 32'h0, {31'h0, rx_level});
        ckp();
        cmp("rx_level", 32'h1, {31'h0, rx_level});
        test_done();
    end
endmodule : tb_sbrg_top
